// ==== core/ram_gate_pkg.sv ====
// Package: constants for the on-chip RAM gate and its control register
package ram_gate_pkg;
  // Address window of the internal RAM
  localparam logic [15:0] RAM_WIN_LO = 16'hf680;
  localparam logic [15:0] RAM_WIN_HI = 16'hfe7f;
  // Control register address on the internal bus
  localparam logic [15:0] RAM_CONTROL_ADDR = 16'hff15;
  // Extra registers on the register port
  localparam logic [15:0] IRQ_STATUS_ADDR = 16'hff16;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'hff17;
  // Field positions of the control register
  localparam int ENABLE_BIT = 7;
  localparam int TEST_BIT = 6;
  localparam int FIXED_BIT = 5;
  localparam int LOW_W = 5;
  // Reset values
  localparam logic ENABLE_RESET = 1'b1;
  localparam logic [4:0] LOW_RESET = 5'h00;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  // Interrupt status bit positions
  localparam int IRQ_ADDR_ERR = 0;
  localparam int IRQ_EXT_ROUTE = 1;
  // Single-chip mode code
  localparam logic [2:0] MODE_SINGLE = 3'h7;
  // Destination of an access
  typedef enum logic [1:0] {DEST_NONE, DEST_RAM, DEST_EXT, DEST_ERR} dest_t;
endpackage : ram_gate_pkg

// ==== core/onchip_ram_gate_decode.sv ====
// Design: on-chip RAM, window decode and RAM control register
//
// Operation
// - 2 kbyte RAM, 16-bit data path
// - Byte and word accesses in two states
// - RAM window F680 through FE7F inclusive
// - Control bit 7 enables internal RAM
// - Enable bit resets to one
// - Standby does not reinitialise enable bit
// - Expanded modes, enabled: window goes internal
// - Expanded modes, disabled: window goes external
// - Single-chip, enabled: window goes internal
// - Single-chip, disabled: window access is address error
// - Bit 6 test bit, undefined value
// - Bit 5 reads one, ignores writes
//
// Notes for users of this block
// - Window decode is combinational on the CPU request.
// - Every CPU answer is registered, so each access takes two states.
// - Internal reads return the whole word; the CPU picks its lane.
// - Address bit 0 is ignored; byte lanes select what is written.
// - Only reset and a control register write change the enable bit.
// - Standby is an input only; it never touches the control register.
// - Mode pins pass a three-stage chain before they are believed.
// - From reset until the pins settle the mode reads as zero, an expanded mode; later changes keep the old mode until they settle.
// - Test bit 6 reads as zero and writes to it are dropped.
// - Status bits are sticky and clear on a read of the status.
// - A new event in the clearing cycle wins over the clear.
// - The RAM array has no reset; its content starts unknown.
// - Unmapped register reads return zero, unmapped writes are lost.
`timescale 1ns/1ps
`default_nettype none
module onchip_ram_gate_decode
  import ram_gate_pkg::*;
#(
  parameter int RAM_BYTES = 2048
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Operating mode pins (1..7)
  input wire logic [2:0] mode_pins,
  // Software standby indication
  input wire logic standby,
  // CPU bus access
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_fetch,
  input wire logic [1:0] cpu_be,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata_ff,
  output logic cpu_done_ff,
  output logic addr_error_ff,
  output logic ext_select_ff,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  // Flash-side control bits
  output logic [4:0] flash_ctrl_ff,
  // Interrupt
  output logic irq_ff
);
  // Derived sizes of the RAM array
  localparam int WORDS = RAM_BYTES / 2; // Sixteen-bit words
  localparam int AW = $clog2(WORDS); // Word index width
  // Bytes covered by the address window
  localparam int WIN_BYTES = int'(RAM_WIN_HI) - int'(RAM_WIN_LO) + 1;

  // Elaboration check: window must fit the array exactly
  if (RAM_BYTES != WIN_BYTES) begin : g_bad_size
    $error("RAM_BYTES must match the address window");
  end
  // Elaboration check: the word index must stay inside the offset
  if (AW < 1 || AW > 15) begin : g_bad_index
    $error("RAM_BYTES gives an unusable word index width");
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode synchroniser (pins come from outside)
  // Pins change at any time against mclk, so the first stage may go
  // metastable; only stages two and three are compared.
  logic [2:0] mode_s1_ff; // First stage, may be metastable
  logic [2:0] mode_s2_ff; // Second stage
  logic [2:0] mode_s3_ff; // Third stage
  logic [2:0] mode_ff; // Accepted mode
  // Chain and acceptance of a settled mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_s1_ff <= 3'h0;
      mode_s2_ff <= 3'h0;
      mode_s3_ff <= 3'h0;
      mode_ff <= 3'h0;
    end else begin
      mode_s1_ff <= mode_pins;
      mode_s2_ff <= mode_s1_ff;
      mode_s3_ff <= mode_s2_ff;
      if (mode_s2_ff == mode_s3_ff) begin
        mode_ff <= mode_s3_ff; // Change counts once stages agree
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register
  // Only the enable bit and the low flash bits are stored; bits 6
  // and 5 are fixed in the read view.
  logic enable_ff; // Internal RAM enable
  logic [4:0] low_ff; // Flash-side bits
  logic [7:0] irq_status_ff; // Sticky events
  logic [7:0] irq_mask_ff; // Event mask
  // Register selects, one per mapped address
  wire sel_ctl = (reg_addr == RAM_CONTROL_ADDR); // Control register hit
  wire sel_stat = (reg_addr == IRQ_STATUS_ADDR); // Status register hit
  wire sel_mask = (reg_addr == IRQ_MASK_ADDR); // Mask register hit
  wire ctl_wr = reg_wr && sel_ctl; // Control write strobe
  wire mask_wr = reg_wr && sel_mask; // Mask write strobe
  wire stat_rd = reg_rd && sel_stat; // Status read, clears status
  wire internal_ram_enable = enable_ff; // Enable as seen by decode

  // Enable bit; reset and control write only, standby input deliberately unused here
  // Standby must not reinitialise the enable, so only the reset and
  // a control write reach these flip-flops.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enable_ff <= ENABLE_RESET;
      low_ff <= LOW_RESET;
    end else if (ctl_wr) begin
      enable_ff <= reg_wdata[ENABLE_BIT];
      low_ff <= reg_wdata[LOW_W-1:0];
    end
  end

  // Control byte as read back: test bit zero, fixed bit one
  wire [7:0] ctl_view = {enable_ff, 1'b0, 1'b1, low_ff};

  ////////////////////////////////////////////////////////////////////////
  // Window decode
  // Both ends of the window count as inside
  wire in_window = (cpu_addr >= RAM_WIN_LO) && (cpu_addr <= RAM_WIN_HI);
  wire single_chip = (mode_ff == MODE_SINGLE); // Single-chip mode only
  wire win_req = cpu_req && in_window; // Request that hits the window
  dest_t dest; // Where the current request goes
  assign dest = !win_req ? DEST_NONE :
                internal_ram_enable ? DEST_RAM :
                single_chip ? DEST_ERR : DEST_EXT;
  // Named destination strobes
  wire ram_sel = (dest == DEST_RAM); // Internal RAM serves it
  wire ext_sel = (dest == DEST_EXT); // Off-chip memory serves it
  wire err_sel = (dest == DEST_ERR); // Address error
  wire ram_rd = ram_sel && !cpu_we; // Internal read or fetch

  ////////////////////////////////////////////////////////////////////////
  // RAM array, word organised with byte lanes
  // No reset on the array: it is plain storage and software must
  // initialise it before use.
  logic [15:0] mem [WORDS];
  wire [15:0] win_off = cpu_addr - RAM_WIN_LO; // Byte offset into window
  wire [AW-1:0] word_idx = win_off[AW:1]; // Word index, bit 0 dropped
  logic [1:0] lane_we; // Lanes written this cycle

  // Byte-lane write enables, generate per lane
  for (genvar b = 0; b < 2; b++) begin : g_lane
    assign lane_we[b] = ram_sel && cpu_we && cpu_be[b];
  end

  // Array write, one process so the array has a single driver
  always_ff @(posedge mclk) begin
    for (int b = 0; b < 2; b++) begin
      if (lane_we[b]) begin
        mem[word_idx][b*8 +: 8] <= cpu_wdata[b*8 +: 8];
      end
    end
  end

  // Access completes one cycle after request: two bus states
  // Each answer is a one-cycle pulse; read data hold until the next
  // internal read so the CPU may take them late.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cpu_rdata_ff <= 16'h0000;
      cpu_done_ff <= 1'b0;
      addr_error_ff <= 1'b0;
      ext_select_ff <= 1'b0;
    end else begin
      cpu_done_ff <= ram_sel;
      addr_error_ff <= err_sel;
      ext_select_ff <= ext_sel;
      if (ram_rd) begin
        cpu_rdata_ff <= mem[word_idx];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and register read
  // Status bits are sticky: a read clears them all, but an event in
  // the same cycle is kept so that no event is ever lost.
  logic [7:0] nxt_status; // Status after this cycle
  // Next status: clear on read, then set by events
  always_comb begin
    nxt_status = stat_rd ? 8'h00 : irq_status_ff;
    if (dest == DEST_ERR) nxt_status[IRQ_ADDR_ERR] = 1'b1; // Set wins over clear
    if (dest == DEST_EXT) nxt_status[IRQ_EXT_ROUTE] = 1'b1;
  end

  // Read selection; unmapped addresses read as zero
  wire [7:0] rd_mux = sel_ctl ? ctl_view :
                      sel_stat ? irq_status_ff :
                      sel_mask ? irq_mask_ff : 8'h00;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_status_ff <= IRQ_RESET;
      irq_mask_ff <= IRQ_RESET;
      irq_ff <= 1'b0;
      reg_rdata_ff <= 8'h00;
      flash_ctrl_ff <= LOW_RESET;
    end else begin
      irq_status_ff <= nxt_status;
      if (mask_wr) irq_mask_ff <= reg_wdata;
      irq_ff <= |(nxt_status & irq_mask_ff);
      reg_rdata_ff <= reg_rd ? rd_mux : 8'h00;
      flash_ctrl_ff <= ctl_wr ? reg_wdata[LOW_W-1:0] : low_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  // Each property but the reset check looks one cycle after the request, matching the
  // two-state answer of the CPU side and of the register port.
  // All but the reset check are disabled while reset is low, so the
  // cycle that releases reset never sees a stale past value.

  // Enable bit comes out of reset set
  enable_reset_a: assert property (@(posedge mclk)
    $rose(resetn) |-> enable_ff)
    else $error("enable not one after reset");

  // Enable only moves on a control write
  enable_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    !ctl_wr |=> $stable(enable_ff))
    else $error("enable changed without write");

  // Standby keeps the enable bit
  standby_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
    (standby && !ctl_wr) |=> $stable(enable_ff))
    else $error("enable changed in standby");

  // Enabled window access is served internally
  ram_route_a: assert property (@(posedge mclk) disable iff (!resetn)
    (cpu_req && in_window && enable_ff) |=> cpu_done_ff && !addr_error_ff)
    else $error("enabled window access not served");

  // Single-chip and enabled: internal RAM, never external
  single_ram_a: assert property (@(posedge mclk) disable iff (!resetn)
    (win_req && enable_ff && single_chip) |=> cpu_done_ff && !ext_select_ff)
    else $error("single-chip enabled access not internal");

  // Expanded and disabled: off-chip memory
  ext_route_a: assert property (@(posedge mclk) disable iff (!resetn)
    (cpu_req && in_window && !enable_ff && !single_chip) |=> ext_select_ff)
    else $error("disabled window not external");

  // Expanded and disabled: neither internal answer nor error
  ext_only_a: assert property (@(posedge mclk) disable iff (!resetn)
    (win_req && !enable_ff && !single_chip) |=> !cpu_done_ff && !addr_error_ff)
    else $error("external access also answered inside");

  // Single-chip and disabled: address error
  addr_err_a: assert property (@(posedge mclk) disable iff (!resetn)
    (cpu_req && in_window && !enable_ff && single_chip) |=> addr_error_ff && !cpu_done_ff)
    else $error("missing address error");

  // Instruction fetch also raises the address error
  fetch_err_a: assert property (@(posedge mclk) disable iff (!resetn)
    (win_req && cpu_fetch && !enable_ff && single_chip) |=> addr_error_ff)
    else $error("fetch into disabled window not refused");

  // Address error sets its sticky status bit
  err_status_a: assert property (@(posedge mclk) disable iff (!resetn)
    err_sel |=> irq_status_ff[IRQ_ADDR_ERR])
    else $error("address error status not set");

  // External route sets its sticky status bit
  ext_status_a: assert property (@(posedge mclk) disable iff (!resetn)
    ext_sel |=> irq_status_ff[IRQ_EXT_ROUTE])
    else $error("external route status not set");

  // A status read with no new event clears the status
  stat_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (stat_rd && !err_sel && !ext_sel) |=> irq_status_ff == IRQ_RESET)
    else $error("status not cleared by read");

  // Nothing answers outside the window
  outside_quiet_a: assert property (@(posedge mclk) disable iff (!resetn)
    (cpu_req && !in_window) |=> !cpu_done_ff && !addr_error_ff && !ext_select_ff)
    else $error("access outside window decoded");

  // Top byte of the window is still inside
  window_edge_a: assert property (@(posedge mclk) disable iff (!resetn)
    (cpu_req && cpu_addr == RAM_WIN_HI && enable_ff) |=> cpu_done_ff)
    else $error("last window byte not served");

  // Fixed bit reads one
  fixed_bit_a: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && reg_addr == RAM_CONTROL_ADDR) |=> reg_rdata_ff[FIXED_BIT])
    else $error("fixed bit not one");

  // Test bit reads zero
  test_bit_a: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && sel_ctl) |=> !reg_rdata_ff[TEST_BIT])
    else $error("test bit not zero");

  // Read data stand only in the cycle after a read
  rd_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
    !reg_rd |=> reg_rdata_ff == 8'h00)
    else $error("read data outside read cycle");

  // Enable bit reads back as stored
  enable_view_a: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && sel_ctl) |=> reg_rdata_ff[ENABLE_BIT] == $past(enable_ff))
    else $error("enable read back wrong");

  // Low bits read back as stored
  low_view_a: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && sel_ctl) |=> reg_rdata_ff[LOW_W-1:0] == $past(low_ff))
    else $error("low bits read back wrong");

  // Low bits reach the flash block
  flash_bits_a: assert property (@(posedge mclk) disable iff (!resetn)
    ctl_wr |=> flash_ctrl_ff == $past(reg_wdata[LOW_W-1:0]))
    else $error("flash bits not stored");

  // Enable follows a control write
  enable_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    ctl_wr |=> enable_ff == $past(reg_wdata[ENABLE_BIT]))
    else $error("enable write lost");

  // Main scenarios
  cover_ram_rd: cover property (@(posedge mclk) cpu_req && in_window && enable_ff && !cpu_we);
  cover_ext: cover property (@(posedge mclk) ext_select_ff);
  cover_err: cover property (@(posedge mclk) addr_error_ff);
  cover_irq: cover property (@(posedge mclk) irq_ff);
  cover_single_ram: cover property (@(posedge mclk) win_req && enable_ff && single_chip);
endmodule : onchip_ram_gate_decode
`default_nettype wire

// ==== dv/cpu_bus_model.sv ====
// CPU-side bus model issuing one-cycle accesses
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  // Clock
  input wire logic mclk,
  // Access request
  output logic cpu_req,
  output logic cpu_we,
  output logic cpu_fetch,
  output logic [1:0] cpu_be,
  output logic [15:0] cpu_addr,
  output logic [15:0] cpu_wdata
);
  initial cpu_req = 1'b0;
  // One-cycle request, then invert address and write data so stale values never help
  task automatic access(input logic we, input logic fe, input logic [1:0] be, input logic [15:0] a,
                        input logic [15:0] d);
    @(posedge mclk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_fetch <= fe;
    cpu_be <= be;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge mclk);
    cpu_req <= 1'b0;
    cpu_addr <= ~a;
    cpu_wdata <= ~d;
  endtask : access
endmodule : cpu_bus_model
`default_nettype wire

// ==== dv/onchip_ram_gate_decode_tb.sv ====
// Self-checking testbench for the on-chip RAM gate
`timescale 1ns/1ps
`default_nettype none
module onchip_ram_gate_decode_tb;
  import ram_gate_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] mode_pins = 3'h3;
  logic standby = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_req, cpu_we, cpu_fetch, cpu_done_ff, addr_error_ff, ext_select_ff, irq_ff, rd_pend;
  logic [1:0] cpu_be;
  logic [15:0] cpu_addr, cpu_wdata, cpu_rdata_ff, a, d;
  logic [7:0] reg_rdata_ff;
  logic [4:0] flash_ctrl_ff;
  logic [19:0] note;
  logic [19:0] cpu_q[$];
  logic [7:0] reg_q[$];
  logic [15:0] mem[int];
  int err_total = 0;
  int total_checks = 0;
  int seed = 30023;
  int cycles = 0;
  always #12.5 mclk = ~mclk;
  cpu_bus_model u_cpu (.mclk, .cpu_req, .cpu_we, .cpu_fetch, .cpu_be, .cpu_addr, .cpu_wdata);
  onchip_ram_gate_decode u_dut (.mclk, .resetn, .mode_pins, .standby, .cpu_req, .cpu_we, .cpu_fetch,
    .cpu_be, .cpu_addr, .cpu_wdata, .cpu_rdata_ff, .cpu_done_ff, .addr_error_ff, .ext_select_ff,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .flash_ctrl_ff, .irq_ff);
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic reg_acc(input logic wr, input logic [15:0] ad, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= ad;
    reg_wdata <= v;
    if (!wr) reg_q.push_back(v);
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : reg_acc
  // Note kind {error, external, done}; reads note the modelled word
  task automatic cpu(input logic we, input logic fe, input logic [1:0] be, input logic [15:0] ad,
                     input logic [15:0] v, input logic [2:0] kind);
    logic [15:0] w;
    w = mem.exists(ad[15:1]) ? mem[ad[15:1]] : 16'h0000;
    if (be[0]) w[7:0] = we ? v[7:0] : w[7:0];
    if (be[1]) w[15:8] = we ? v[15:8] : w[15:8];
    if (kind == 3'h1 && we) mem[ad[15:1]] = w;
    if (kind != 3'h0) cpu_q.push_back({~we & kind[0], kind, w});
    u_cpu.access(we, fe, be, ad, v);
  endtask : cpu
  task automatic irq_is(input logic v);
    repeat (2) @(negedge mclk);
    check({19'h0, irq_ff}, {19'h0, v});
  endtask : irq_is
  // Result watcher, one cycle after each request
  always @(negedge mclk) begin
    if (rd_pend === 1'b1) check({12'h0, reg_rdata_ff}, {12'h0, reg_q.pop_front()});
    rd_pend = reg_rd;
    if (cpu_done_ff | addr_error_ff | ext_select_ff) begin
      note = cpu_q.size() > 0 ? cpu_q.pop_front() : 20'hfffff;
      check({note[19], addr_error_ff, ext_select_ff, cpu_done_ff, note[19] ? cpu_rdata_ff : note[15:0]},
            note);
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    reg_acc(0, RAM_CONTROL_ADDR, 8'ha0);
    reg_acc(0, 16'hff20, 8'h00);
    for (int i = 0; i < 4; i++) begin
      a = i == 0 ? RAM_WIN_LO : i == 1 ? 16'hfe7e : 16'hf680 + 16'(2 * ({$random(seed)} % 1024));
      d = 16'($random(seed));
      cpu(1, 0, 2'h3, a, d, 3'h1);
      cpu(0, 0, 2'h3, a, 16'h0, 3'h1);
      cpu(1, 0, 2'h2, a | 16'h1, ~d, 3'h1);
      cpu(0, 1, 2'h3, a, 16'h0, 3'h1);
    end
    cpu(0, 0, 2'h3, 16'hf67e, 16'h0, 3'h0);
    cpu(1, 0, 2'h3, 16'hfe80, d, 3'h0);
    reg_acc(1, IRQ_MASK_ADDR, 8'h03);
    reg_acc(1, RAM_CONTROL_ADDR, 8'h5f);
    reg_acc(0, RAM_CONTROL_ADDR, 8'h3f);
    check({15'h0, flash_ctrl_ff}, 20'h1f);
    standby <= 1'b1;
    repeat (3) @(posedge mclk);
    standby <= 1'b0;
    reg_acc(0, RAM_CONTROL_ADDR, 8'h3f);
    cpu(1, 0, 2'h3, 16'hf700, d, 3'h2);
    irq_is(1'b1);
    reg_acc(0, IRQ_STATUS_ADDR, 8'h02);
    irq_is(1'b0);
    mode_pins <= MODE_SINGLE;
    repeat (5) @(posedge mclk);
    cpu(0, 1, 2'h3, 16'hf680, 16'h0, 3'h4);
    cpu(0, 0, 2'h1, 16'hfe7f, 16'h0, 3'h4);
    cpu(1, 0, 2'h3, 16'hf900, d, 3'h4);
    reg_acc(0, IRQ_STATUS_ADDR, 8'h01);
    reg_acc(1, RAM_CONTROL_ADDR, 8'h80);
    cpu(1, 0, 2'h3, 16'hf900, d, 3'h1);
    cpu(0, 0, 2'h3, 16'hf900, 16'h0, 3'h1);
    reg_acc(1, RAM_CONTROL_ADDR, 8'h00);
    repeat (2) @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    repeat (5) @(posedge mclk);
    reg_acc(0, RAM_CONTROL_ADDR, 8'ha0);
    repeat (3) @(posedge mclk);
    check(20'(cpu_q.size()), 20'h0);
    print_verdict();
  end
endmodule : onchip_ram_gate_decode_tb
`default_nettype wire
